/* File: cpu_ctrl_pkg.sv */
// Constants, modes and states for the processor control and address generator.
package cpu_ctrl_pkg;

   // ----------------------------------------------------------------
   // Fixed addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_VEC_LO = 16'hfffc;
   localparam logic [15:0] RST_VEC_HI = 16'hfffd;
   localparam logic [7:0]  STACK_PAGE = 8'h01;
   localparam logic [7:0]  ZERO_PAGE  = 8'h00;

   // ----------------------------------------------------------------
   // Reset values and cycle counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  SP_INIT      = 8'hff;
   localparam logic [15:0] PC_INIT      = 16'h0000;
   localparam int          RST_CYCLES   = 7;
   localparam logic [2:0]  RST_LAST     = 3'(RST_CYCLES - 1);
   localparam logic [2:0]  RST_VEC_STEP = 3'(RST_CYCLES - 2);
   localparam logic [1:0]  HALT_CYCLES  = 2'd2;

   // ----------------------------------------------------------------
   // Addressing modes, taken from opcode bits 3..0
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      M_IMM  = 4'h0, M_ABS  = 4'h1, M_ZP   = 4'h2, M_ACC  = 4'h3,
      M_IMP  = 4'h4, M_ZPIY = 4'h5, M_ZPXI = 4'h6, M_ZPX  = 4'h7,
      M_ZPY  = 4'h8, M_ABX  = 4'h9, M_ABY  = 4'ha, M_REL  = 4'hb,
      M_ABSI = 4'hc, M_STK  = 4'hd, M_ABXI = 4'he, M_ZPI  = 4'hf
   } mode_e;

   // Access kind, taken from opcode bits 5..4.
   typedef enum logic [1:0] {
      K_READ = 2'b00, K_WRITE = 2'b01, K_RMW = 2'b10, K_JUMP = 2'b11
   } kind_e;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_HALT  = 4'h0, S_RST   = 4'h1, S_FETCH = 4'h2, S_OPER1 = 4'h3,
      S_OPER2 = 4'h4, S_IDX   = 4'h5, S_PTRLO = 4'h6, S_PTRHI = 4'h7,
      S_FIX   = 4'h8, S_EXEC  = 4'h9, S_MOD   = 4'ha, S_WRB   = 4'hb,
      S_BR    = 4'hc, S_IDLE  = 4'hd, S_STKP  = 4'he, S_STK   = 4'hf
   } state_e;

endpackage

/* File: cpu_control_addr.sv */
// Processor control pins and effective address sequencer.
`timescale 1ns/1ns

// Summary of operation
// - Reset input low for two cycles halts the sequencer; the set-overflow input still sets the overflow flag.
// - Reset input rising edge starts a seven-cycle reset sequence.
// - Reset sets interrupt disable, clears decimal, loads PC from FFFC/FFFD.
// - Falling set-overflow input, sampled on rising clock, sets overflow flag.
// - Opcode-fetch indicator high exactly during opcode fetch cycles.
// - Ready low during a fetch cycle holds the core until ready returns.
// - Vector pull low during the two vector read cycles only.
// - Bus enable asynchronously enables or floats address, data, read/write.
// - Stack accesses always fall in page 0100 to 01FF.
// - Immediate uses byte two; absolute bytes two/three; zero page byte two.
// - (zp),Y reads zero-page pointer then adds Y.
// - (zp,X) adds X to byte two, reads effective address there.
// - zp,X and zp,Y add the index to the zero-page address.
// - Absolute indexed adds X or Y to the 16-bit base.
// - Taken branch adds signed byte two to PC of next opcode.
// - Absolute indirect jump loads PC from pointer, low byte first.
// - Absolute indexed indirect jump adds X to operand to form pointer.
// - Zero-page indirect reads effective address from zero-page pointer.
// - Indexed address crossing a page costs one extra cycle.
// - Taken branch costs one cycle more than its two-cycle base.
// - Read-modify-write takes two cycles more than the base count.
// - Halted core resumes only after a low-then-high edge on the reset input, via the reset sequence.
module cpu_control_addr (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        resetInN,
   input  wire logic        setOverflowInN,
   input  wire logic        clearOverflow,
   input  wire logic        busDriveEn,
   input  wire logic        readyIn,
   input  wire logic [7:0]  dataIn,
   input  wire logic [7:0]  writeData,
   input  wire logic [7:0]  indexX,
   input  wire logic [7:0]  indexY,
   output logic      [15:0] addrOut,
   output logic             addrOe,
   output logic      [7:0]  dataOut,
   output logic             dataOe,
   output logic             readWriteN,
   output logic             readWriteOe,
   output logic             opcodeFetch,
   output logic             vectorPullN,
   output logic      [15:0] pcOut,
   output logic             irqDisable,
   output logic             decimalMode,
   output logic             overflowFlag,
   output logic             opDone,
   output logic      [15:0] opAddr,
   output logic      [7:0]  opData
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cpu_ctrl_pkg::state_e state_q, state_d;
   logic [15:0] pc_q, pc_d, base_q, base_d, ptr_q, ptr_d, ea_q, ea_d;
   logic [7:0]  opc_q, opc_d, sp_q, sp_d, data_q, data_d;
   logic [2:0]  rstCnt_q, rstCnt_d;
   logic [1:0]  lowCnt_q, lowCnt_d;
   logic        resPrev_q, soPrev_q, i_q, i_d, dec_q, dec_d, v_q, v_d;
   logic [15:0] addr_q, addr_d, opAddr_q, opAddr_d;
   logic [7:0]  wd_q, wd_d, opData_q, opData_d;
   logic        rw_q, rw_d, sync_q, sync_d, vp_q, vp_d, done_q, done_d;

   cpu_ctrl_pkg::mode_e mode, modeD;
   cpu_ctrl_pkg::kind_e kind, kindD;
   logic [7:0]  idx;
   logic [15:0] full, fullIdx, ptrFull;
   logic [7:0]  zpSum;
   logic        haltNow, taken, zpPtr;

   assign mode    = cpu_ctrl_pkg::mode_e'(opc_q[3:0]);
   assign kind    = cpu_ctrl_pkg::kind_e'(opc_q[5:4]);
   assign modeD   = cpu_ctrl_pkg::mode_e'(opc_d[3:0]);
   assign kindD   = cpu_ctrl_pkg::kind_e'(opc_d[5:4]);
   assign idx     = (mode == cpu_ctrl_pkg::M_ZPY || mode == cpu_ctrl_pkg::M_ABY ||
                     mode == cpu_ctrl_pkg::M_ZPIY) ? indexY : indexX;
   assign full    = {dataIn, base_q[7:0]};
   assign fullIdx = full + {8'h00, idx};
   assign ptrFull = {dataIn, ea_q[7:0]};
   assign zpSum   = base_q[7:0] + idx;
   assign taken   = opc_q[7] | (v_q == opc_q[6]);
   assign zpPtr   = (modeD == cpu_ctrl_pkg::M_ZPIY || modeD == cpu_ctrl_pkg::M_ZPXI ||
                     modeD == cpu_ctrl_pkg::M_ZPI);
   // Taken from the registered count so the halt test does not loop through the next-state block.
   assign haltNow = !resetInN && (lowCnt_q >= cpu_ctrl_pkg::HALT_CYCLES - 2'd1);

   // ----------------------------------------------------------------
   // Next state, effective address and bus cycle
   // ----------------------------------------------------------------
   always_comb begin
      state_d  = state_q;
      pc_d     = pc_q;
      opc_d    = opc_q;
      base_d   = base_q;
      ptr_d    = ptr_q;
      ea_d     = ea_q;
      rstCnt_d = rstCnt_q;
      sp_d     = sp_q;
      i_d      = i_q;
      dec_d    = dec_q;
      v_d      = v_q;
      data_d   = data_q;
      done_d   = 1'b0;
      opAddr_d = opAddr_q;
      opData_d = opData_q;
      lowCnt_d = resetInN ? 2'd0 :
                 (lowCnt_q == cpu_ctrl_pkg::HALT_CYCLES) ? lowCnt_q : lowCnt_q + 2'd1;
      // Set beats clear so an edge in the clearing cycle is not lost.
      if (clearOverflow) begin
         v_d = 1'b0;
      end
      if (soPrev_q && !setOverflowInN) begin
         v_d = 1'b1;
      end
      if (haltNow) begin
         state_d = cpu_ctrl_pkg::S_HALT;
      end else if (state_q == cpu_ctrl_pkg::S_HALT) begin
         // Leaving halt needs a low-then-high edge on the reset input.
         if (!resPrev_q && resetInN) begin
            state_d  = cpu_ctrl_pkg::S_RST;
            rstCnt_d = 3'd0;
         end
      end else if (state_q == cpu_ctrl_pkg::S_RST) begin
         if (rstCnt_q == 3'd0) begin
            i_d   = 1'b1;
            dec_d = 1'b0;
         end
         if (rstCnt_q == cpu_ctrl_pkg::RST_VEC_STEP) begin
            pc_d[7:0] = dataIn;
         end
         if (rstCnt_q == cpu_ctrl_pkg::RST_LAST) begin
            pc_d[15:8] = dataIn;
            state_d    = cpu_ctrl_pkg::S_FETCH;
         end else begin
            rstCnt_d = rstCnt_q + 3'd1;
         end
      end else if (readyIn) begin
         unique case (state_q)
            cpu_ctrl_pkg::S_FETCH: begin
               opc_d = dataIn;
               pc_d  = pc_q + 16'h0001;
               unique case (cpu_ctrl_pkg::mode_e'(dataIn[3:0]))
                  cpu_ctrl_pkg::M_ACC, cpu_ctrl_pkg::M_IMP: state_d = cpu_ctrl_pkg::S_IDLE;
                  cpu_ctrl_pkg::M_STK:                      state_d = cpu_ctrl_pkg::S_STKP;
                  default:                                  state_d = cpu_ctrl_pkg::S_OPER1;
               endcase
            end
            cpu_ctrl_pkg::S_OPER1: begin
               base_d = {cpu_ctrl_pkg::ZERO_PAGE, dataIn};
               pc_d   = pc_q + 16'h0001;
               unique case (mode)
                  cpu_ctrl_pkg::M_IMM: begin
                     done_d   = 1'b1;
                     opAddr_d = pc_q;
                     opData_d = dataIn;
                     state_d  = cpu_ctrl_pkg::S_FETCH;
                  end
                  cpu_ctrl_pkg::M_ZP: begin
                     ea_d    = {cpu_ctrl_pkg::ZERO_PAGE, dataIn};
                     state_d = cpu_ctrl_pkg::S_EXEC;
                  end
                  cpu_ctrl_pkg::M_ZPIY, cpu_ctrl_pkg::M_ZPI: begin
                     ptr_d   = {cpu_ctrl_pkg::ZERO_PAGE, dataIn};
                     state_d = cpu_ctrl_pkg::S_PTRLO;
                  end
                  cpu_ctrl_pkg::M_ZPX, cpu_ctrl_pkg::M_ZPY, cpu_ctrl_pkg::M_ZPXI:
                     state_d = cpu_ctrl_pkg::S_IDX;
                  cpu_ctrl_pkg::M_REL:
                     state_d = taken ? cpu_ctrl_pkg::S_BR : cpu_ctrl_pkg::S_FETCH;
                  default:
                     state_d = cpu_ctrl_pkg::S_OPER2;
               endcase
            end
            cpu_ctrl_pkg::S_OPER2: begin
               base_d = full;
               pc_d   = pc_q + 16'h0001;
               unique case (mode)
                  cpu_ctrl_pkg::M_ABX, cpu_ctrl_pkg::M_ABY: begin
                     ea_d    = fullIdx;
                     state_d = (fullIdx[15:8] != dataIn) ? cpu_ctrl_pkg::S_FIX
                                                         : cpu_ctrl_pkg::S_EXEC;
                  end
                  cpu_ctrl_pkg::M_ABSI: begin
                     ptr_d   = full;
                     state_d = cpu_ctrl_pkg::S_PTRLO;
                  end
                  cpu_ctrl_pkg::M_ABXI: begin
                     ptr_d   = fullIdx;
                     state_d = cpu_ctrl_pkg::S_PTRLO;
                  end
                  default: begin
                     if (kind == cpu_ctrl_pkg::K_JUMP) begin
                        pc_d    = full;
                        state_d = cpu_ctrl_pkg::S_FETCH;
                     end else begin
                        ea_d    = full;
                        state_d = cpu_ctrl_pkg::S_EXEC;
                     end
                  end
               endcase
            end
            cpu_ctrl_pkg::S_IDX: begin
               if (mode == cpu_ctrl_pkg::M_ZPXI) begin
                  ptr_d   = {cpu_ctrl_pkg::ZERO_PAGE, zpSum};
                  state_d = cpu_ctrl_pkg::S_PTRLO;
               end else begin
                  ea_d    = {cpu_ctrl_pkg::ZERO_PAGE, zpSum};
                  state_d = cpu_ctrl_pkg::S_EXEC;
               end
            end
            cpu_ctrl_pkg::S_PTRLO: begin
               ea_d[7:0] = dataIn;
               state_d   = cpu_ctrl_pkg::S_PTRHI;
            end
            cpu_ctrl_pkg::S_PTRHI: begin
               if (mode == cpu_ctrl_pkg::M_ABSI || mode == cpu_ctrl_pkg::M_ABXI) begin
                  pc_d    = ptrFull;
                  state_d = cpu_ctrl_pkg::S_FETCH;
               end else if (mode == cpu_ctrl_pkg::M_ZPIY) begin
                  base_d  = ptrFull;
                  ea_d    = ptrFull + {8'h00, indexY};
                  state_d = (ea_d[15:8] != dataIn) ? cpu_ctrl_pkg::S_FIX
                                                   : cpu_ctrl_pkg::S_EXEC;
               end else begin
                  ea_d    = ptrFull;
                  state_d = cpu_ctrl_pkg::S_EXEC;
               end
            end
            cpu_ctrl_pkg::S_FIX:
               state_d = cpu_ctrl_pkg::S_EXEC;
            cpu_ctrl_pkg::S_EXEC: begin
               opAddr_d = ea_q;
               if (kind == cpu_ctrl_pkg::K_RMW) begin
                  data_d  = dataIn;
                  state_d = cpu_ctrl_pkg::S_MOD;
               end else begin
                  done_d   = 1'b1;
                  opData_d = (kind == cpu_ctrl_pkg::K_WRITE) ? writeData : dataIn;
                  state_d  = cpu_ctrl_pkg::S_FETCH;
               end
            end
            cpu_ctrl_pkg::S_MOD:
               state_d = cpu_ctrl_pkg::S_WRB;
            cpu_ctrl_pkg::S_WRB: begin
               done_d   = 1'b1;
               opData_d = data_q + 8'h01;
               state_d  = cpu_ctrl_pkg::S_FETCH;
            end
            cpu_ctrl_pkg::S_BR: begin
               pc_d    = pc_q + {{8{base_q[7]}}, base_q[7:0]};
               state_d = cpu_ctrl_pkg::S_FETCH;
            end
            cpu_ctrl_pkg::S_STKP:
               state_d = cpu_ctrl_pkg::S_STK;
            cpu_ctrl_pkg::S_STK: begin
               done_d  = 1'b1;
               state_d = cpu_ctrl_pkg::S_FETCH;
               if (kind == cpu_ctrl_pkg::K_WRITE) begin
                  opAddr_d = {cpu_ctrl_pkg::STACK_PAGE, sp_q};
                  opData_d = writeData;
                  sp_d     = sp_q - 8'h01;
               end else begin
                  opAddr_d = {cpu_ctrl_pkg::STACK_PAGE, sp_q + 8'h01};
                  opData_d = dataIn;
                  sp_d     = sp_q + 8'h01;
               end
            end
            default:
               state_d = cpu_ctrl_pkg::S_IDLE == state_q ? cpu_ctrl_pkg::S_FETCH : state_q;
         endcase
      end
      // Bus cycle for the state being entered; outputs are registered.
      addr_d = pc_d;
      rw_d   = 1'b1;
      wd_d   = wd_q;
      vp_d   = 1'b1;
      sync_d = (state_d == cpu_ctrl_pkg::S_FETCH);
      unique case (state_d)
         cpu_ctrl_pkg::S_RST: begin
            if (rstCnt_d == cpu_ctrl_pkg::RST_VEC_STEP) begin
               addr_d = cpu_ctrl_pkg::RST_VEC_LO;
               vp_d   = 1'b0;
            end else if (rstCnt_d == cpu_ctrl_pkg::RST_LAST) begin
               addr_d = cpu_ctrl_pkg::RST_VEC_HI;
               vp_d   = 1'b0;
            end else begin
               addr_d = {cpu_ctrl_pkg::STACK_PAGE, sp_d};
            end
         end
         cpu_ctrl_pkg::S_IDX:   addr_d = {cpu_ctrl_pkg::ZERO_PAGE, base_d[7:0]};
         cpu_ctrl_pkg::S_PTRLO: addr_d = ptr_d;
         cpu_ctrl_pkg::S_PTRHI: addr_d = zpPtr ? {cpu_ctrl_pkg::ZERO_PAGE, ptr_d[7:0] + 8'h01}
                                               : ptr_d + 16'h0001;
         cpu_ctrl_pkg::S_FIX:   addr_d = {base_d[15:8], ea_d[7:0]};
         cpu_ctrl_pkg::S_EXEC: begin
            addr_d = ea_d;
            rw_d   = (kindD != cpu_ctrl_pkg::K_WRITE);
            wd_d   = writeData;
         end
         cpu_ctrl_pkg::S_MOD: begin
            addr_d = ea_d;
            rw_d   = 1'b0;
            wd_d   = data_d;
         end
         cpu_ctrl_pkg::S_WRB: begin
            addr_d = ea_d;
            rw_d   = 1'b0;
            wd_d   = data_d + 8'h01;
         end
         cpu_ctrl_pkg::S_STK: begin
            rw_d   = (kindD != cpu_ctrl_pkg::K_WRITE);
            wd_d   = writeData;
            addr_d = {cpu_ctrl_pkg::STACK_PAGE, rw_d ? sp_d + 8'h01 : sp_d};
         end
         default: addr_d = pc_d;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= cpu_ctrl_pkg::S_HALT;
         pc_q      <= cpu_ctrl_pkg::PC_INIT;
         opc_q     <= 8'h00;
         base_q    <= 16'h0000;
         ptr_q     <= 16'h0000;
         ea_q      <= 16'h0000;
         sp_q      <= cpu_ctrl_pkg::SP_INIT;
         data_q    <= 8'h00;
         rstCnt_q  <= 3'd0;
         lowCnt_q  <= 2'd0;
         resPrev_q <= 1'b1;
         soPrev_q  <= 1'b1;
         i_q       <= 1'b1;
         dec_q     <= 1'b0;
         v_q       <= 1'b0;
         addr_q    <= cpu_ctrl_pkg::PC_INIT;
         wd_q      <= 8'h00;
         rw_q      <= 1'b1;
         sync_q    <= 1'b0;
         vp_q      <= 1'b1;
         done_q    <= 1'b0;
         opAddr_q  <= 16'h0000;
         opData_q  <= 8'h00;
      end else begin
         state_q   <= state_d;
         pc_q      <= pc_d;
         opc_q     <= opc_d;
         base_q    <= base_d;
         ptr_q     <= ptr_d;
         ea_q      <= ea_d;
         sp_q      <= sp_d;
         data_q    <= data_d;
         rstCnt_q  <= rstCnt_d;
         lowCnt_q  <= lowCnt_d;
         resPrev_q <= resetInN;
         soPrev_q  <= setOverflowInN;
         i_q       <= i_d;
         dec_q     <= dec_d;
         v_q       <= v_d;
         addr_q    <= addr_d;
         wd_q      <= wd_d;
         rw_q      <= rw_d;
         sync_q    <= sync_d;
         vp_q      <= vp_d;
         done_q    <= done_d;
         opAddr_q  <= opAddr_d;
         opData_q  <= opData_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Bus enable must float the pins at once, so the enables bypass the flops.
   assign addrOe       = busDriveEn;
   assign readWriteOe  = busDriveEn;
   assign dataOe       = busDriveEn & ~rw_q;
   assign addrOut      = addr_q;
   assign dataOut      = wd_q;
   assign readWriteN   = rw_q;
   assign opcodeFetch  = sync_q;
   assign vectorPullN  = vp_q;
   assign pcOut        = pc_q;
   assign irqDisable   = i_q;
   assign decimalMode  = dec_q;
   assign overflowFlag = v_q;
   assign opDone       = done_q;
   assign opAddr       = opAddr_q;
   assign opData       = opData_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence rstRun_s;
      (state_q == cpu_ctrl_pkg::S_RST && rstCnt_q == 3'd0) ##6 (rstCnt_q == 3'd6);
   endsequence
   sequence vecPull_s;
      (addrOut == 16'hfffc && !vectorPullN) ##1 (addrOut == 16'hfffd && !vectorPullN);
   endsequence

   rst_length_a: assert property (state_q == cpu_ctrl_pkg::S_HALT && state_d == cpu_ctrl_pkg::S_RST
      && resetInN |=> rstRun_s ##1 (state_q != cpu_ctrl_pkg::S_RST))
      else $error("reset sequence length wrong");
   halt_low_a: assert property (!resetInN && !$past(resetInN)
      |=> state_q == cpu_ctrl_pkg::S_HALT)
      else $error("core not halted by reset input");
   rst_vector_a: assert property (state_q == cpu_ctrl_pkg::S_RST && rstCnt_q == 3'd6 && !haltNow
      |=> irqDisable && !decimalMode && pcOut[15:8] == $past(dataIn))
      else $error("reset vector or flags wrong");
   so_set_a: assert property ($fell(setOverflowInN) |=> overflowFlag)
      else $error("overflow not set");
   fetch_bus_a: assert property (opcodeFetch |-> addrOut == pcOut && readWriteN)
      else $error("fetch cycle not at program counter");
   ready_hold_a: assert property (opcodeFetch && !readyIn && !haltNow
      |=> opcodeFetch && $stable(addrOut))
      else $error("core moved while not ready");
   vector_pull_a: assert property ($fell(vectorPullN) && resetInN |-> vecPull_s)
      else $error("vector pull window wrong");
   stack_page_a: assert property (state_q == cpu_ctrl_pkg::S_STK |-> addrOut[15:8] == 8'h01)
      else $error("stack access off page one");
   page_fix_a: assert property (state_q == cpu_ctrl_pkg::S_FIX && readyIn && !haltNow
      |=> state_q == cpu_ctrl_pkg::S_EXEC && addrOut == ea_q)
      else $error("page fix cycle wrong");
   branch_add_a: assert property (state_q == cpu_ctrl_pkg::S_BR && readyIn && !haltNow
      |=> pc_q == $past(pc_q) + {{8{$past(base_q[7])}}, $past(base_q[7:0])})
      else $error("branch target wrong");
   rmw_steps_a: assert property (state_q == cpu_ctrl_pkg::S_EXEC && kind == cpu_ctrl_pkg::K_RMW
      && readyIn && !haltNow |=> !readWriteN ##1 (!readWriteN && opDone == 1'b0))
      else $error("modify cycles missing");

endmodule // cpu_control_addr

/* File: mem_model.sv */
// Behavioural memory that answers the core's bus.
`timescale 1ns/1ns
module mem_model (
   input  wire logic        sys_clk,
   input  wire logic [15:0] addrOut,
   input  wire logic        readWriteN,
   input  wire logic        readyIn,
   input  wire logic [7:0]  dataOut,
   output logic      [7:0]  dataIn
);
   localparam logic [23:0] IMG [17] = '{24'hfffc00, 24'hfffd02, 24'h020001, 24'h020134,
      24'h020212, 24'h020309, 24'h0204f0, 24'h020512, 24'h123477, 24'h020711, 24'h020840,
      24'h020912, 24'h020a22, 24'h020b80, 24'h020c8b, 24'h020d02, 24'h02101d};
   logic [7:0] mem [65536];
   initial begin
      foreach (mem[i]) mem[i] = 8'h04;
      foreach (IMG[i]) mem[IMG[i][23:8]] = IMG[i][7:0];
   end
   // A stalled write is stored once only, at the accepted edge.
   always @(posedge sys_clk) if (!readWriteN && readyIn) mem[addrOut] <= dataOut;
   // On write cycles the read line carries junk, never a byte worth trusting.
   assign dataIn = readWriteN ? mem[addrOut] : ~mem[addrOut];
endmodule // mem_model

/* File: tb.sv */
// Self-checking bench for the control pins and address sequencer.
`timescale 1ns/1ns
module tb;
   logic sys_clk = 0, nrst = 0, resetInN = 0, setOverflowInN = 1, busDriveEn = 1, readyIn = 1;
   logic [7:0]  dataIn, dataOut, opData;
   logic [7:0]  indexX = 8'h20;
   logic [15:0] addrOut, pcOut, opAddr;
   logic addrOe, dataOe, readWriteN, readWriteOe, opcodeFetch, vectorPullN;
   logic irqDisable, decimalMode, overflowFlag, opDone;
   int num_errors = 0, samples_checked = 0, cycles = 0, n;
   initial forever #5 sys_clk = ~sys_clk;
   cpu_control_addr u_cpu_control_addr (.sys_clk(sys_clk), .nrst(nrst), .resetInN(resetInN),
      .setOverflowInN(setOverflowInN), .clearOverflow(1'b0), .busDriveEn(busDriveEn),
      .readyIn(readyIn), .dataIn(dataIn), .writeData(8'h3c), .indexX(indexX),
      .indexY(8'h00), .addrOut(addrOut), .addrOe(addrOe), .dataOut(dataOut),
      .dataOe(dataOe), .readWriteN(readWriteN), .readWriteOe(readWriteOe),
      .opcodeFetch(opcodeFetch), .vectorPullN(vectorPullN), .pcOut(pcOut),
      .irqDisable(irqDisable), .decimalMode(decimalMode), .overflowFlag(overflowFlag),
      .opDone(opDone), .opAddr(opAddr), .opData(opData));
   mem_model u_mem_model (.sys_clk(sys_clk), .addrOut(addrOut), .readWriteN(readWriteN),
      .readyIn(readyIn), .dataOut(dataOut), .dataIn(dataIn));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (exp !== got) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Backstop only: every wait loop below already gives up after 40 cycles.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic step(output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         #1 k++;
      end while (opDone !== 1'b1 && k < 40);
   endtask
   task automatic reset_seq();
      int vp = 0;
      n = 0;
      repeat (3) @(posedge sys_clk);
      #1 resetInN = 1;
      do begin
         @(posedge sys_clk);
         #2 n++;
         if (vectorPullN === 1'b0) vp++;
      end while (opcodeFetch !== 1'b1 && n < 40);
      check("reset cycles", 16'd8, 16'(n));
      check("vector pull", 16'd2, 16'(vp));
      check("fetch addr", 16'h0200, addrOut);
      check("flags", 16'h0001, {14'h0, decimalMode, irqDisable});
   endtask
   task automatic abs_ops();
      step(n);
      check("abs ea", 16'h1234, opAddr);
      check("abs data", 16'h0077, {8'h00, opData});
      step(n);
      check("abx ea", 16'h1310, opAddr);
      check("abx cycles", 16'd5, 16'(n));
   endtask
   // Entered in the cycle whose edge raised the fetch indicator for the byte at 0206.
   task automatic ready_stall();
      readyIn = 0;
      check("stall fetch", 16'h0001, {15'h0, opcodeFetch});
      repeat (3) @(posedge sys_clk);
      #1 check("stall addr", 16'h0206, addrOut);
      check("stall sync", 16'h0001, {15'h0, opcodeFetch});
      check("stall pc", 16'h0206, pcOut);
      readyIn = 1;
      @(posedge sys_clk);
      #1 check("resume addr", 16'h0207, addrOut);
   endtask
   task automatic write_op();
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (readWriteN !== 1'b0 && n < 40);
      check("write addr", 16'h1240, addrOut);
      check("write data", 16'h003c, {8'h00, dataOut});
      check("write oe", 16'h0007, {13'h0, addrOe, readWriteOe, dataOe});
      step(n);
      check("write done", 16'h1240, opAddr);
      check("stored", 16'h003c, {8'h00, u_mem_model.mem[16'h1240]});
   endtask
   task automatic more_ops();
      step(n);
      check("rmw cycles", 16'd5, 16'(n));
      check("rmw data", 16'h0005, {8'h00, opData});
      step(n);
      check("branch push cycles", 16'd6, 16'(n));
      check("push addr", 16'h01ff, opAddr);
   endtask
   task automatic ovf_and_float();
      check("overflow idle", 16'h0000, {15'h0, overflowFlag});
      setOverflowInN = 0;
      repeat (2) @(posedge sys_clk);
      #1 check("overflow", 16'h0001, {15'h0, overflowFlag});
      busDriveEn = 0;
      #1 check("float oe", 16'h0000, {13'h0, addrOe, readWriteOe, dataOe});
      @(posedge sys_clk);
      #1 busDriveEn = 1;
   endtask
   // A running core alternates fetch and idle, so two quiet samples in a row mean halted.
   task automatic mid_reset();
      resetInN = 0;
      repeat (2) @(posedge sys_clk);
      #1 check("halt sync", 16'h0000, {15'h0, opcodeFetch});
      @(posedge sys_clk);
      #1 check("halt hold", 16'h0000, {15'h0, opcodeFetch});
      reset_seq();
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 nrst = 1;
      reset_seq();
      abs_ops();
      ready_stall();
      write_op();
      more_ops();
      ovf_and_float();
      mid_reset();
      report_and_stop();
   end
endmodule // tb
